/* File: dv/spdc_link_chk.sv */
// Purpose: checks on the link pins between host and device ends
// Assumes: shift clock half period of four sysclk cycles
// Notes:   two sync flops give the device two cycles of lag
`timescale 1ns/1ps
module spdc_link_chk (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ser_clk,
   input wire logic load_strobe,
   input wire logic phase_sense_select,
   input wire logic pump_o,
   input wire logic pump_oe,
   input wire logic bypass_pin_o,
   input wire logic bypass_pin_oe,
   input wire logic ref_pump_o,
   input wire logic var_pump_o,
   input wire logic var_pump_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ----------------------------------------
   // serial load port
   // ----------------------------------------
   sequence s_sclk_hi;
      ser_clk [*4];
   endsequence
   sequence s_sclk_lo;
      !ser_clk [*4];
   endsequence
   property p_sclk_hi;
      $rose(ser_clk) |-> s_sclk_hi ##1 !ser_clk;
   endproperty
   a_sclk_hi: assert property (p_sclk_hi) else $error("shift clock high phase wrong");
   property p_sclk_lo;
      $fell(ser_clk) |-> s_sclk_lo;
   endproperty
   a_sclk_lo: assert property (p_sclk_lo) else $error("shift clock low phase short");
   property p_quiet;
      load_strobe |-> !ser_clk;
   endproperty
   a_quiet: assert property (p_quiet) else $error("shift clock moved under strobe");
   // ----------------------------------------
   // bypass switch and pump outputs
   // ----------------------------------------
   // strobe reaches the switch through two sync flops
   sequence s_strobe_on;
      load_strobe [*3];
   endsequence
   sequence s_strobe_off;
      !load_strobe [*3];
   endsequence
   property p_byp_on;
      s_strobe_on ##0 pump_oe |-> bypass_pin_oe;
   endproperty
   a_byp_on: assert property (p_byp_on) else $error("bypass not switched on");
   property p_byp_off;
      s_strobe_off |-> !bypass_pin_oe;
   endproperty
   a_byp_off: assert property (p_byp_off) else $error("bypass not released");
   property p_byp_val;
      bypass_pin_oe && pump_oe |-> bypass_pin_o == pump_o;
   endproperty
   a_byp_val: assert property (p_byp_val) else $error("bypass does not follow pump");
   property p_hi_up;
      phase_sense_select && pump_oe && pump_o |-> !ref_pump_o && var_pump_oe && !var_pump_o;
   endproperty
   a_hi_up: assert property (p_hi_up) else $error("pump high mapping wrong");
   property p_hi_dn;
      phase_sense_select && pump_oe && !pump_o |-> ref_pump_o && !var_pump_oe;
   endproperty
   a_hi_dn: assert property (p_hi_dn) else $error("pump low mapping wrong");
   property p_lo_up;
      !phase_sense_select && pump_oe && pump_o |-> !ref_pump_o && var_pump_oe && !var_pump_o;
   endproperty
   a_lo_up: assert property (p_lo_up) else $error("inverted pump mapping wrong");
   property p_idle;
      !pump_oe |-> !ref_pump_o && !var_pump_oe;
   endproperty
   a_idle: assert property (p_idle) else $error("pumps not idle at equality");
endmodule

/* File: dv/test_serial_pll_divider_core.sv */
// Purpose: both ends joined, driven over AXI4-Lite from the host side
// Assumes: osc and vco ticks every cycle, so periods are plain ratios
// Notes:   windows with exact checks span whole periods, so those counts are exact
`timescale 1ns/1ps
module test_serial_pll_divider_core;
   import spdc_pkg::*;
   logic        clk_sys = 1'b0;
   logic        srst, osc_tick, vco_tick, mod_hi, pre_lg;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          failures = 0;
   int          cmp_count = 0;
   always #12.5 clk_sys = ~clk_sys;
   spdc_link_if i_spdc_link_if ();
   spdc_host i_spdc_host (.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lnk(i_spdc_link_if));
   spdc_dev i_spdc_dev (.clk_sys(clk_sys), .srst(srst), .osc_tick(osc_tick), .vco_tick(vco_tick),
      .modulus_high_sel(mod_hi), .prescaler_large(pre_lg), .lnk(i_spdc_link_if));
   spdc_link_chk i_spdc_link_chk (.clk_sys(clk_sys), .srst(srst), .ser_clk(i_spdc_link_if.ser_clk),
      .load_strobe(i_spdc_link_if.load_strobe), .phase_sense_select(i_spdc_link_if.phase_sense_select),
      .pump_o(i_spdc_link_if.pump_o), .pump_oe(i_spdc_link_if.pump_oe),
      .bypass_pin_o(i_spdc_link_if.bypass_pin_o), .bypass_pin_oe(i_spdc_link_if.bypass_pin_oe),
      .ref_pump_o(i_spdc_link_if.ref_pump_o), .var_pump_o(i_spdc_link_if.var_pump_o),
      .var_pump_oe(i_spdc_link_if.var_pump_oe));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok, b_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      b_ok = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_ok) begin
         @(posedge clk_sys);
         b_ok = aw_ok && w_ok && bvalid;
         aw_ok = aw_ok || awready;
         w_ok = w_ok || wready;
         awvalid <= !aw_ok;
         wvalid <= !w_ok;
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_ok, done;
      ar_ok = 1'b0;
      done = 1'b0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         done = ar_ok && rvalid;
         ar_ok = ar_ok || arready;
         arvalid <= !ar_ok;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // frame load, then poll busy so the next frame never overlaps
   task automatic load(input logic [3:0] a, input logic [31:0] v, input logic [31:0] c);
      logic [1:0]  r;
      logic [31:0] d;
      axi_wr(a, v, r);
      axi_wr(A_CTRL, c, r);
      d = 32'h1;
      while (d[0] !== 1'b0) axi_rd(A_STAT, d, r);
      repeat (8) @(posedge clk_sys);
   endtask
   // sel 0 monitor rises, 1 large modulus cycles, 2 lock low cycles
   task automatic cnt(input int sel, input int cyc, output int n);
      logic prv;
      prv = i_spdc_link_if.compare_mon;
      n = 0;
      repeat (cyc) begin
         @(posedge clk_sys);
         if (sel == 0) n += (i_spdc_link_if.compare_mon && !prv);
         if (sel == 1) n += pre_lg;
         if (sel == 2) n += !i_spdc_link_if.lock_detect_out;
         prv = i_spdc_link_if.compare_mon;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(A_STAT, d, r);
      chk(32'h2, d & 32'h3, "status after reset");
      chk({31'h0, REF_LATCH_RST[MOD_SEL_POS]}, mod_hi, "modulus after reset");
      chk(32'h1, i_spdc_link_if.phase_sense_select, "sense after reset");
      $display("test reset done");
   endtask
   task automatic t_ref;
      load(A_REF, 32'h10, 32'h7);
      chk(32'h0, mod_hi, "modulus low frame");
      load(A_MAIN, 32'h800, 32'h5);
      chk(32'h0, mod_hi, "modulus after main frame");
      load(A_REF, 32'h11, 32'h7);
      chk(32'h1, mod_hi, "modulus high frame");
      $display("test latch select done");
   endtask
   task automatic t_count;
      int          n;
      logic [1:0]  r;
      repeat (40) @(posedge clk_sys);
      cnt(0, 80, n);
      chk(32'd10, n, "reference pulses");
      cnt(1, 160, n);
      chk(32'd0, n, "large modulus, swallow 0");
      cnt(2, 200, n);
      chk(32'h1, n > 0, "lock low on offset");
      load(A_MAIN, 32'h803, 32'h5);
      repeat (40) @(posedge clk_sys);
      cnt(1, 160, n);
      chk(32'd30, n, "large modulus, swallow 3");
      axi_wr(A_CTRL, 32'h0, r);
      repeat (40) @(posedge clk_sys);
      chk(32'h0, i_spdc_link_if.phase_sense_select, "sense low");
      cnt(0, 160, n);
      chk(32'd10, n, "monitor shows variable");
      axi_wr(A_CTRL, 32'h4, r);
      $display("test counters done");
   endtask
   task automatic t_unmapped;
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(4'h2, 32'h0, r);
      chk(RESP_SLVERR, r, "write unmapped resp");
      axi_rd(4'h2, d, r);
      chk(RESP_SLVERR, r, "read unmapped resp");
      chk(32'h0, d, "read unmapped data");
      $display("test unmapped done");
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      osc_tick = 1'b0;
      vco_tick = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      osc_tick <= 1'b1;
      vco_tick <= 1'b1;
      t_reset;
      t_ref;
      t_count;
      t_unmapped;
      final_report;
   end
   // ample margin over about sixteen hundred cycles of tests
   initial begin
      #500000;
      failures++;
      final_report;
   end
endmodule

/* File: logic/spdc_dev.sv */
// Purpose: serially programmed synthesizer digital core (device end)
// Assumes: osc and vco ticks are one-cycle enables on clk_sys
// Notes:   link pins are synchronised by two flops before use
`timescale 1ns/1ps
module spdc_dev
   import spdc_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic osc_tick,
   input  wire logic vco_tick,
   output logic      modulus_high_sel,
   output logic      prescaler_large,
   spdc_link_if.dev  lnk
);
   // ------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic       clk_old_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         // idle pin levels, so no false shift edge or transfer after reset
         s1_q      <= 4'h8;
         s2_q      <= 4'h8;
         clk_old_q <= 1'b0;
      end else begin
         s1_q      <= {lnk.phase_sense_select, lnk.load_strobe, lnk.ser_clk, lnk.ser_data};
         s2_q      <= s1_q;
         clk_old_q <= s2_q[1];
      end
   end
   wire sdat   = s2_q[0];
   wire sclk_r = s2_q[1] & ~clk_old_q;
   wire strobe = s2_q[2];
   wire sense  = s2_q[3];

   // ------------------------------------------------
   // shift register and latches
   // ------------------------------------------------
   logic [MAIN_FRAME_W-1:0] shift_q;
   logic [REF_LATCH_W-1:0]  ref_latch_q;
   logic [MAIN_LATCH_W-1:0] main_latch_q;
   // one 19-bit chain; the reference frame is its low 16 bits
   wire                     sel_bit = shift_q[0];
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shift_q      <= '0;
         ref_latch_q  <= REF_LATCH_RST;
         main_latch_q <= MAIN_LATCH_RST;
      end else begin
         if (sclk_r) begin
            shift_q <= {shift_q[MAIN_FRAME_W-2:0], sdat};
         end
         if (strobe && !sclk_r) begin
            if (sel_bit) begin
               ref_latch_q <= shift_q[REF_FRAME_W-1:1];
            end else begin
               main_latch_q <= shift_q[MAIN_FRAME_W-1:1];
            end
         end
      end
   end

   // ------------------------------------------------
   // reference divider
   // ------------------------------------------------
   // 14-bit counter from latch bits 1..14
   wire [REF_CNT_W-1:0] ref_ratio = ref_latch_q[REF_LATCH_W-1:REF_RATIO_LO];
   logic [REF_CNT_W-1:0] ref_cnt_q;
   logic                 fr_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ref_cnt_q <= '0;
         fr_q      <= 1'b0;
      end else begin
         fr_q <= 1'b0;
         if (osc_tick) begin
            if (ref_cnt_q <= 14'h0001) begin
               ref_cnt_q <= ref_ratio;
               fr_q      <= 1'b1;
            end else begin
               ref_cnt_q <= ref_cnt_q - 14'h0001;
            end
         end
      end
   end
   assign modulus_high_sel = ref_latch_q[MOD_SEL_POS];

   // ------------------------------------------------
   // pulse swallow divider
   // ------------------------------------------------
   // 7-bit swallow and 11-bit main
   wire [SWAL_CNT_W-1:0] swal_ratio = main_latch_q[SWAL_LO+SWAL_CNT_W-1:SWAL_LO];
   wire [MAIN_CNT_W-1:0] main_ratio = main_latch_q[MAIN_LATCH_W-1:MAIN_LO];
   logic [SWAL_CNT_W-1:0] swal_cnt_q;
   logic [MAIN_CNT_W-1:0] main_cnt_q;
   logic                  fp_q;
   // vco_tick is one prescaler output cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         swal_cnt_q <= '0;
         main_cnt_q <= '0;
         fp_q       <= 1'b0;
      end else begin
         fp_q <= 1'b0;
         if (vco_tick) begin
            if (main_cnt_q <= 11'h001) begin
               main_cnt_q <= main_ratio;
               swal_cnt_q <= swal_ratio;
               fp_q       <= 1'b1;
            end else begin
               main_cnt_q <= main_cnt_q - 11'h001;
               if (swal_cnt_q != '0) begin
                  swal_cnt_q <= swal_cnt_q - 7'h01;
               end
            end
         end
      end
   end
   assign prescaler_large = (swal_cnt_q != '0);

   // ------------------------------------------------
   // phase frequency comparator
   // ------------------------------------------------
   // tri-state pfd spans +-2pi
   logic up_q;
   logic dn_q;
   logic [1:0] spike_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         up_q    <= 1'b0;
         dn_q    <= 1'b0;
         spike_q <= 2'h0;
      end else begin
         if ((up_q | fr_q) && (dn_q | fp_q)) begin
            up_q    <= 1'b0;
            dn_q    <= 1'b0;
            spike_q <= 2'(SPIKE_CYC);
         end else begin
            up_q <= up_q | fr_q;
            dn_q <= dn_q | fp_q;
            if (spike_q != 2'h0) begin
               spike_q <= spike_q - 2'h1;
            end
         end
      end
   end
   wire ref_ahead = up_q & ~dn_q;
   wire var_ahead = dn_q & ~up_q;
   wire drive_up  = sense ? ref_ahead : var_ahead;
   wire drive_dn  = sense ? var_ahead : ref_ahead;
   // equality spike is a short down pulse, same mapping as a down drive
   wire spike_dn  = (spike_q != 2'h0) & ~drive_up;
   assign lnk.pump_o      = drive_up;
   assign lnk.pump_oe     = drive_up | drive_dn | spike_dn;
   assign lnk.ref_pump_o  = drive_dn | spike_dn;
   assign lnk.var_pump_o  = 1'b0;
   assign lnk.var_pump_oe = drive_up;
   assign lnk.bypass_pin_o  = drive_up;
   assign lnk.bypass_pin_oe = strobe & lnk.pump_oe;
   assign lnk.compare_mon = sense ? fr_q : fp_q;
   assign lnk.lock_detect_out = ~(up_q | dn_q);
endmodule

/* File: logic/spdc_host.sv */
// Purpose: host end, loads frames over the three-wire port
// Assumes: software writes ratios over AXI4-Lite
// Notes:   shift clock made by a divider of clk_sys
`timescale 1ns/1ps
module spdc_host
   import spdc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   spdc_link_if.host        lnk
);
   // ------------------------------------------------
   // registers
   // ------------------------------------------------
   logic [REF_LATCH_W-1:0]  ref_q;
   logic [MAIN_LATCH_W-1:0] main_q;
   logic                    sense_q;
   logic                    go_q;
   logic                    go_sel_q;
   logic                    busy_q;
   logic                    aw_q;
   logic                    w_q;
   logic [3:0]              awa_q;
   logic [31:0]             wd_q;
   logic [1:0]              lk_s_q;
   wire do_wr  = aw_q & w_q & ~s_axi_bvalid;
   wire hit_r  = (awa_q == A_REF);
   wire hit_m  = (awa_q == A_MAIN);
   wire hit_c  = (awa_q == A_CTRL);
   wire wr_ok  = hit_r | hit_m | hit_c;
   wire start  = do_wr & hit_c & wd_q[0] & ~busy_q;
   assign s_axi_awready = ~aw_q;
   assign s_axi_wready  = ~w_q;
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ref_q <= REF_LATCH_RST; main_q <= MAIN_LATCH_RST;
         sense_q <= 1'b1; go_q <= 1'b0; go_sel_q <= 1'b0;
         aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 4'h0; wd_q <= 32'h0;
         s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0; s_axi_rresp <= RESP_OKAY; s_axi_rdata <= 32'h0;
         lk_s_q <= 2'h3;
      end else begin
         lk_s_q <= {lk_s_q[0], lnk.lock_detect_out};
         go_q <= 1'b0;
         if (s_axi_awvalid && !aw_q) begin
            aw_q  <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_q <= 1'b0; w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (hit_r) ref_q <= wd_q[REF_LATCH_W-1:0];
            if (hit_m) main_q <= wd_q[MAIN_LATCH_W-1:0];
            if (hit_c) sense_q <= wd_q[2];
            go_q     <= start;
            go_sel_q <= wd_q[1];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == A_REF) s_axi_rdata <= 32'(ref_q);
            else if (s_axi_araddr == A_MAIN) s_axi_rdata <= 32'(main_q);
            else if (s_axi_araddr == A_CTRL) s_axi_rdata <= {29'h0, sense_q, go_sel_q, 1'b0};
            else if (s_axi_araddr == A_STAT) s_axi_rdata <= {30'h0, lk_s_q[1], busy_q};
            else begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------
   // frame shifter
   // ------------------------------------------------
   spdc_host_st_t           st_q;
   logic [MAIN_FRAME_W-1:0] fr_q;
   logic [4:0]              left_q;
   logic [2:0]              div_q;
   logic                    sck_q;
   wire tick = (div_q == 3'(SCLK_HALF_CYC - 1));
   assign busy_q = (st_q != SPDC_IDLE);
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= SPDC_IDLE; fr_q <= '0; left_q <= 5'h0; div_q <= 3'h0; sck_q <= 1'b0;
      end else begin
         div_q <= tick ? 3'h0 : div_q + 3'h1;
         case (st_q)
            SPDC_IDLE: begin
               sck_q <= 1'b0;
               if (go_q) begin
                  fr_q   <= go_sel_q ? {ref_q, 1'b1, 3'h0} : {main_q, 1'b0};
                  left_q <= go_sel_q ? 5'(REF_FRAME_W) : 5'(MAIN_FRAME_W);
                  st_q   <= SPDC_SHIFT;
               end
            end
            SPDC_SHIFT: begin
               if (tick) begin
                  sck_q <= ~sck_q;
                  if (sck_q) begin
                     fr_q   <= {fr_q[MAIN_FRAME_W-2:0], 1'b0};
                     left_q <= left_q - 5'h1;
                     if (left_q == 5'h1) st_q <= SPDC_LOAD;
                  end
               end
            end
            default: begin
               // sck_q only times the strobe here; ser_clk is gated off
               if (tick) begin
                  sck_q <= ~sck_q;
                  if (sck_q) begin
                     st_q <= SPDC_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign lnk.ser_data = fr_q[MAIN_FRAME_W-1];
   assign lnk.ser_clk  = (st_q == SPDC_SHIFT) & sck_q;
   assign lnk.load_strobe = (st_q == SPDC_LOAD);
   // software picks sense per vco slope
   assign lnk.phase_sense_select = sense_q;
endmodule

/* File: logic/spdc_link_if.sv */
// Purpose: three-wire load port plus loop observation pins
// Assumes: bench resolves high impedance from the enables
// Notes:   no clocking block
`timescale 1ns/1ps
interface spdc_link_if;
   logic ser_data;
   logic ser_clk;
   logic load_strobe;
   logic phase_sense_select;
   logic pump_o;
   logic pump_oe;
   logic bypass_pin_o;
   logic bypass_pin_oe;
   logic ref_pump_o;
   logic var_pump_o;
   logic var_pump_oe;
   logic compare_mon;
   logic lock_detect_out;
   modport dev (
      input  ser_data, ser_clk, load_strobe, phase_sense_select,
      output pump_o, pump_oe, bypass_pin_o, bypass_pin_oe, ref_pump_o, var_pump_o, var_pump_oe,
      compare_mon, lock_detect_out
   );
   modport host (
      output ser_data, ser_clk, load_strobe, phase_sense_select,
      input  pump_o, pump_oe, bypass_pin_o, bypass_pin_oe, ref_pump_o, var_pump_o, var_pump_oe,
      compare_mon, lock_detect_out
   );
endinterface

/* File: logic/spdc_pkg.sv */
// Purpose: shared constants for the serial synthesizer core and its host end
// Assumes: frames shifted msb first, select bit last
// Notes:   widths, counts, bit positions, reset values, register map, response codes and host states; no identity codes
package spdc_pkg;
   localparam int REF_FRAME_W  = 16;
   localparam int MAIN_FRAME_W = 19;
   localparam int REF_LATCH_W  = 15;
   localparam int MAIN_LATCH_W = 18;
   localparam int REF_CNT_W    = 14;
   localparam int SWAL_CNT_W   = 7;
   localparam int MAIN_CNT_W   = 11;
   localparam int REF_MIN      = 8;
   localparam int MAIN_MIN     = 16;
   // modulus select position within the reference latch
   localparam int MOD_SEL_POS  = 0;
   localparam int REF_RATIO_LO = 1;
   localparam int SWAL_LO      = 0;
   localparam int MAIN_LO      = 7;
   // reset values of the reference and main latches
   localparam logic [REF_LATCH_W-1:0]  REF_LATCH_RST  = 15'h0011;
   localparam logic [MAIN_LATCH_W-1:0] MAIN_LATCH_RST = 18'h00800;
   // sysclk cycles per half period of the generated shift clock
   localparam int SCLK_HALF_CYC = 4;
   // pump pulse widening around equality, in sysclk cycles
   localparam int SPIKE_CYC     = 1;
   // AXI4-Lite register map of the host end
   localparam logic [3:0] A_REF  = 4'h0;
   localparam logic [3:0] A_MAIN = 4'h4;
   localparam logic [3:0] A_CTRL = 4'h8;
   localparam logic [3:0] A_STAT = 4'hC;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      SPDC_IDLE  = 2'b00,
      SPDC_SHIFT = 2'b01,
      SPDC_LOAD  = 2'b10
   } spdc_host_st_t;
endpackage
